// ### logic/hpqm_pkg.sv
// shared constants for the packet queue manager and its bus master
`default_nettype none
package hpqm_pkg;
	// sizes
	localparam int NQ = 8;
	localparam int QW = 3;
	localparam int DEPTH = 16;
	localparam int DPW = 4;
	localparam int CW = 5;
	localparam int NC = 4;
	localparam int CIDW = 2;
	localparam int AW = 14;
	// address layout: region [13:12], queue [11:4], word [3:2]
	localparam int RGN_LSB = 12;
	localparam int QSEL_LSB = 4;
	localparam int QSEL_TOP = 11;
	localparam int WSEL_LSB = 2;
	localparam logic [1:0] RGN_MGMT = 2'h0;
	localparam logic [1:0] RGN_PROXY = 2'h1;
	localparam logic [1:0] RGN_STAT = 2'h2;
	localparam logic [1:0] WORD_A = 2'h0;
	localparam logic [1:0] WORD_B = 2'h1;
	localparam logic [1:0] WORD_C = 2'h2;
	localparam logic [1:0] WORD_D = 2'h3;
	// control word fields and reset values
	localparam int CTRL_HEAD_BIT = 31;
	localparam int CTRL_LEN_W = 17;
	localparam logic [31:0] CTRL_RST = 32'h0;
	localparam logic [CW-1:0] THR_RST = 5'h0;
	// queue roles
	localparam logic [QW-1:0] QP_LO = 3'h2;
	localparam logic [QW-1:0] QP_HI = 3'h3;
	localparam logic [QW-1:0] FREEQ_BASE = 3'h4;
	// host register offsets
	localparam logic [4:0] HREG_CMD = 5'h00;
	localparam logic [4:0] HREG_PTR = 5'h04;
	localparam logic [4:0] HREG_CTRL = 5'h08;
	localparam logic [4:0] HREG_STAT = 5'h0c;
	localparam logic [4:0] HREG_RES = 5'h10;
	localparam logic [4:0] HREG_DMA = 5'h14;
	// host command fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_Q_LSB = 8;
	localparam int CMD_CORE_LSB = 12;
	localparam logic [2:0] OP_PUSH = 3'h0;
	localparam logic [2:0] OP_PAIR = 3'h1;
	localparam logic [2:0] OP_POP = 3'h2;
	localparam logic [2:0] OP_SETC = 3'h3;
	localparam logic [2:0] OP_THR = 3'h4;
	localparam logic [2:0] OP_RX = 3'h5;
	// host dma config fields
	localparam int DMA_TXEN_BIT = 0;
	localparam int DMA_TXQ_LSB = 4;
	localparam int DMA_CMPQ_LSB = 8;
	localparam int DMA_FREEQ_LSB = 12;
	localparam int DMA_RXQ_LSB = 16;
	localparam logic [31:0] HREG_RST = 32'h0;
endpackage
`default_nettype wire

// ### logic/hpqm_bus_if.sv
// bus between the queue manager and the cores / packet move engine
`timescale 1ns/10ps
`default_nettype none
interface hpqm_bus_if;
	import hpqm_pkg::*;
	logic [AW-1:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [CIDW-1:0] mid;
	logic [31:0] rdata;
	logic [NQ-1:0] pend;
	modport dev (input addr, wdata, wr, rd, mid, output rdata, pend);
	modport mst (output addr, wdata, wr, rd, mid, input rdata, pend);
endinterface
`default_nettype wire

// ### logic/hpqm_dev.sv
// queue manager with push proxy and pending lines
// Notes on behaviour
// (RULE_01) push writes descriptor pointer to queue address
// (RULE_02) control bit picks head or tail placement
// (RULE_03) unwritten control word means tail append
// (RULE_04) each queue has its own address set
// (RULE_05) pop returns head then advances head
// (RULE_06) proxy control plus push pair is atomic
// (RULE_07) proxy offsets mirror the normal queue region
// (RULE_08) proxy tracks pairs by bus master id
// (RULE_09) simultaneous proxy pairs granted round robin
// (RULE_10) push word alone accepted in normal region
// (RULE_11) proxy is write only, reads give zero
// (RULE_12) proxy ignores the two count words
// (RULE_13) threads within one core serialise pairs themselves
// (RULE_14) transmit channel watches one queue pending line
// (RULE_15) queue-pend line active at programmed threshold
// (RULE_16) transmitted descriptor goes to completion queue
// (RULE_17) receive pops free queues, pushes receive queue
// (RULE_18) receive fills popped packets, ignores prelinked buffers
// (RULE_19) monolithic free descriptor fields never read
// (RULE_20) receive free packets carry one unchained buffer
// (RULE_21) buffer descriptor never starts a chain
// (RULE_22) pop returns pointer with its size hint; the code returns the pointer word alone, the hint is read from word B
// (RULE_23) empty pop returns zero, state unchanged
// (RULE_24) pending line high while queue non-empty
`timescale 1ns/10ps
`default_nettype none
module hpqm_dev
	import hpqm_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// bus from cores and packet move engine
	hpqm_bus_if.dev BUS,
	// queue-pend lines to interrupt controllers
	output logic [NQ-1:0] QPEND_O
);

	// address decode
	logic [1:0] rgn;
	logic [QW-1:0] q_idx;
	logic [1:0] wsel;
	logic q_ok;
	logic mg_wr;
	logic mg_rd;
	logic px_wr;
	logic st_wr;
	logic st_rd;

	// queue storage and state
	logic [31:0] ptr_mem [0:NQ-1][0:DEPTH-1];
	logic [CTRL_LEN_W-1:0] len_mem [0:NQ-1][0:DEPTH-1];
	logic [DPW-1:0] head_r [0:NQ-1];
	logic [CW-1:0] cnt_r [0:NQ-1];
	logic [31:0] ctrl_r [0:NQ-1];
	logic [CW-1:0] thr_r [0:NQ-1];
	logic [31:0] rdata_r;

	// proxy per-core pair slots
	logic [31:0] pc_r [0:NC-1];
	logic [NC-1:0] pcv_r;
	logic [31:0] pd_r [0:NC-1];
	logic [QW-1:0] pq_r [0:NC-1];
	logic [NC-1:0] prdy_r;
	logic [CIDW-1:0] rr_r;
	logic [CIDW-1:0] gnt;
	logic [CIDW-1:0] rr_idx;
	logic px_any;

	// queue operation of this cycle
	logic op_push;
	logic op_pop;
	logic px_take;
	logic [QW-1:0] op_q;
	logic [31:0] op_word;
	logic [31:0] op_ctrl;
	logic op_full;
	logic op_empty;
	logic [DPW-1:0] wr_idx;
	logic [31:0] pop_val;
	logic [31:0] rd_val;

	// decode region, queue and word from the byte address
	assign rgn = BUS.addr[RGN_LSB+1:RGN_LSB];
	assign q_idx = BUS.addr[QSEL_LSB+QW-1:QSEL_LSB]; // RULE_04
	assign wsel = BUS.addr[WSEL_LSB+1:WSEL_LSB]; // RULE_07
	assign q_ok = (BUS.addr[QSEL_TOP:QSEL_LSB+QW] == '0);
	assign mg_wr = BUS.wr && q_ok && (rgn == RGN_MGMT);
	assign mg_rd = BUS.rd && q_ok && (rgn == RGN_MGMT);
	assign px_wr = BUS.wr && q_ok && (rgn == RGN_PROXY);
	assign st_wr = BUS.wr && q_ok && (rgn == RGN_STAT);
	assign st_rd = BUS.rd && q_ok && (rgn == RGN_STAT);

	// round robin pick among cores holding a finished pair
	always_comb begin
		gnt = rr_r;
		rr_idx = rr_r;
		px_any = |prdy_r;
		for (int k = NC; k >= 1; k--) begin
			rr_idx = rr_r + CIDW'(k);
			if (prdy_r[rr_idx]) begin
				gnt = rr_idx; // RULE_09
			end
		end
	end

	// one queue operation per cycle, bus first, proxy in free cycles
	always_comb begin
		op_push = 1'b0;
		op_pop = 1'b0;
		px_take = 1'b0;
		op_q = q_idx;
		op_word = BUS.wdata;
		op_ctrl = ctrl_r[q_idx];
		if (mg_wr && wsel == WORD_D) begin
			op_push = 1'b1; // RULE_01 RULE_10
		end else if (mg_rd && wsel == WORD_D) begin
			op_pop = 1'b1; // RULE_05
		end else if (px_any) begin
			op_push = 1'b1;
			px_take = 1'b1;
			op_q = pq_r[gnt];
			op_word = pd_r[gnt];
			op_ctrl = pc_r[gnt]; // RULE_06
		end
	end

	// placement and occupancy
	assign op_full = (cnt_r[op_q] == CW'(DEPTH));
	assign op_empty = (cnt_r[op_q] == '0);
	always_comb begin
		if (op_ctrl[CTRL_HEAD_BIT]) begin
			wr_idx = head_r[op_q] - 1'b1; // RULE_02
		end else begin
			wr_idx = head_r[op_q] + cnt_r[op_q][DPW-1:0]; // RULE_03
		end
	end

	// head pointer word without its size hint, zero when empty
	assign pop_val = op_empty ? 32'h0 : ptr_mem[op_q][head_r[op_q]]; // RULE_22 RULE_23

	// pointer and length storage
	always_ff @(posedge CLK_I) begin
		if (op_push && !op_full) begin
			ptr_mem[op_q][wr_idx] <= op_word;
			len_mem[op_q][wr_idx] <= op_ctrl[CTRL_LEN_W-1:0];
		end
	end

	// head pointer and count per queue
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			for (int i = 0; i < NQ; i++) begin
				head_r[i] <= '0;
				cnt_r[i] <= '0;
			end
		end else if (op_push && !op_full) begin
			if (op_ctrl[CTRL_HEAD_BIT]) begin
				head_r[op_q] <= wr_idx; // RULE_02
			end
			cnt_r[op_q] <= cnt_r[op_q] + 1'b1;
		end else if (op_pop && !op_empty) begin
			head_r[op_q] <= head_r[op_q] + 1'b1; // RULE_05
			cnt_r[op_q] <= cnt_r[op_q] - 1'b1;
		end
	end

	// control and threshold words
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			for (int i = 0; i < NQ; i++) begin
				ctrl_r[i] <= CTRL_RST; // RULE_03
				thr_r[i] <= THR_RST;
			end
		end else begin
			if (px_take) begin
				ctrl_r[op_q] <= op_ctrl;
			end
			if (mg_wr && wsel == WORD_C) begin
				ctrl_r[q_idx] <= BUS.wdata;
			end
			if (st_wr && wsel == WORD_D) begin
				thr_r[q_idx] <= BUS.wdata[CW-1:0];
			end
		end
	end

	// proxy slots, one per bus master id
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			for (int c = 0; c < NC; c++) begin
				pc_r[c] <= CTRL_RST;
				pd_r[c] <= 32'h0;
				pq_r[c] <= '0;
			end
			pcv_r <= '0;
			prdy_r <= '0;
			rr_r <= '0;
		end else begin
			if (px_take) begin
				prdy_r[gnt] <= 1'b0;
				rr_r <= gnt;
			end
			// words A and B are never taken through the proxy
			if (px_wr && wsel == WORD_C) begin // RULE_12
				pc_r[BUS.mid] <= BUS.wdata; // RULE_08
				pcv_r[BUS.mid] <= 1'b1;
			end
			if (px_wr && wsel == WORD_D && !(prdy_r[BUS.mid] && !(px_take && gnt == BUS.mid))) begin
				pd_r[BUS.mid] <= BUS.wdata;
				pq_r[BUS.mid] <= q_idx;
				prdy_r[BUS.mid] <= 1'b1; // RULE_06 RULE_08
				pcv_r[BUS.mid] <= 1'b0;
				if (!pcv_r[BUS.mid]) begin
					pc_r[BUS.mid] <= ctrl_r[q_idx];
				end
			end
		end
	end

	// read data mux
	always_comb begin
		rd_val = 32'h0; // RULE_11
		if (mg_rd) begin
			case (wsel)
				WORD_A: rd_val = {{(32-CW){1'b0}}, cnt_r[q_idx]};
				WORD_B: rd_val = cnt_r[q_idx] == '0 ? 32'h0 :
					{{(32-CTRL_LEN_W){1'b0}}, len_mem[q_idx][head_r[q_idx]]};
				WORD_C: rd_val = ctrl_r[q_idx];
				default: rd_val = pop_val; // RULE_05
			endcase
		end else if (st_rd && wsel == WORD_D) begin
			rd_val = {{(32-CW){1'b0}}, thr_r[q_idx]};
		end
	end

	// read data one cycle after the strobe
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rdata_r <= 32'h0;
		end else begin
			rdata_r <= rd_val;
		end
	end
	assign BUS.rdata = rdata_r;

	// pending lines, one per queue
	genvar gq;
	generate
		for (gq = 0; gq < NQ; gq++) begin : g_pend
			logic qp_role;
			logic [CW-1:0] thr_eff;
			assign qp_role = (QW'(gq) >= QP_LO) && (QW'(gq) <= QP_HI);
			assign thr_eff = (thr_r[gq] == '0) ? CW'(1) : thr_r[gq];
			assign BUS.pend[gq] = (cnt_r[gq] != '0); // RULE_14 RULE_24
			assign QPEND_O[gq] = qp_role && (cnt_r[gq] >= thr_eff); // RULE_15
		end
	endgenerate

endmodule // hpqm_dev
`default_nettype wire

// ### logic/hpqm_host.sv
// bus master end: core commands plus packet move engine recycling
`timescale 1ns/10ps
`default_nettype none
module hpqm_host
	import hpqm_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// bus towards the queue manager
	hpqm_bus_if.mst BUS,
	// software register port
	input wire logic [4:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [31:0] RDATA_O
);

	typedef enum logic [2:0] {H_IDLE, H_CTRL, H_PUSH, H_POP, H_WAIT} hpqm_hst_t;

	hpqm_hst_t st_r;
	logic [31:0] ptr_r;
	logic [31:0] ctrl_r;
	logic [31:0] res_r;
	logic [31:0] dma_r;
	logic [31:0] wd_r;
	logic [QW-1:0] q_r;
	logic [QW-1:0] fwd_q_r;
	logic fwd_r;
	logic pair_r;
	logic [1:0] rgn_r;
	logic [CIDW-1:0] mid_r;
	logic [31:0] rdata_r;
	logic cmd_go;
	logic tx_go;
	logic [2:0] cmd_op;
	logic [QW-1:0] dma_txq;

	assign cmd_go = WR_I && (ADDR_I == HREG_CMD) && (st_r == H_IDLE);
	assign cmd_op = WDATA_I[CMD_OP_LSB+2:CMD_OP_LSB];
	assign dma_txq = dma_r[DMA_TXQ_LSB+QW-1:DMA_TXQ_LSB];
	assign tx_go = !cmd_go && (st_r == H_IDLE) && dma_r[DMA_TXEN_BIT] && BUS.pend[dma_txq]; // RULE_14

	// software-written registers
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ptr_r <= HREG_RST;
			ctrl_r <= HREG_RST;
			dma_r <= HREG_RST;
		end else if (WR_I) begin
			case (ADDR_I)
				HREG_PTR: ptr_r <= WDATA_I;
				HREG_CTRL: ctrl_r <= WDATA_I;
				HREG_DMA: dma_r <= WDATA_I;
				default: ;
			endcase
		end
	end

	// transfer sequencer, at most one bus strobe per state
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st_r <= H_IDLE;
			wd_r <= 32'h0;
			q_r <= '0;
			fwd_q_r <= '0;
			fwd_r <= 1'b0;
			pair_r <= 1'b0;
			rgn_r <= RGN_MGMT;
			mid_r <= '0;
			res_r <= 32'h0;
		end else begin
			case (st_r)
				H_IDLE: begin
					if (cmd_go) begin
						q_r <= WDATA_I[CMD_Q_LSB+QW-1:CMD_Q_LSB];
						mid_r <= WDATA_I[CMD_CORE_LSB+CIDW-1:CMD_CORE_LSB];
						wd_r <= ptr_r;
						fwd_r <= 1'b0;
						pair_r <= 1'b0;
						rgn_r <= RGN_MGMT;
						case (cmd_op)
							OP_PUSH: st_r <= H_PUSH; // RULE_10
							OP_PAIR: begin
								rgn_r <= RGN_PROXY; // RULE_13
								pair_r <= 1'b1;
								st_r <= H_CTRL;
							end
							OP_SETC: st_r <= H_CTRL;
							OP_THR: begin
								rgn_r <= RGN_STAT;
								st_r <= H_PUSH;
							end
							OP_RX: begin
								q_r <= FREEQ_BASE + dma_r[DMA_FREEQ_LSB+1:DMA_FREEQ_LSB]; // RULE_17
								fwd_q_r <= dma_r[DMA_RXQ_LSB+QW-1:DMA_RXQ_LSB];
								fwd_r <= 1'b1;
								st_r <= H_POP;
							end
							default: st_r <= H_POP;
						endcase
					end else if (tx_go) begin
						q_r <= dma_txq;
						fwd_q_r <= dma_r[DMA_CMPQ_LSB+QW-1:DMA_CMPQ_LSB];
						fwd_r <= 1'b1;
						rgn_r <= RGN_MGMT;
						st_r <= H_POP;
					end
				end
				H_CTRL: st_r <= pair_r ? H_PUSH : H_IDLE; // RULE_06
				H_POP: st_r <= H_WAIT;
				H_WAIT: begin
					res_r <= BUS.rdata;
					// popped word forwarded untouched, no descriptor fields read
					// only the popped start-of-packet word is ever pushed onward
					wd_r <= BUS.rdata; // RULE_19 RULE_21 RULE_22
					q_r <= fwd_q_r;
					fwd_r <= 1'b0;
					if (fwd_r && BUS.rdata != 32'h0) begin
						st_r <= H_PUSH; // RULE_16 RULE_17 RULE_18
					end else begin
						st_r <= H_IDLE;
					end
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end

	// bus drive from sequencer state
	always_comb begin
		BUS.addr = {rgn_r, {(QSEL_TOP-QSEL_LSB-QW+1){1'b0}}, q_r, WORD_A, 2'h0};
		BUS.wdata = 32'h0;
		BUS.wr = 1'b0;
		BUS.rd = 1'b0;
		BUS.mid = mid_r;
		case (st_r)
			H_CTRL: begin
				BUS.addr[WSEL_LSB+1:WSEL_LSB] = WORD_C;
				BUS.wdata = ctrl_r;
				BUS.wr = 1'b1;
			end
			H_PUSH: begin
				BUS.addr[WSEL_LSB+1:WSEL_LSB] = WORD_D;
				BUS.wdata = wd_r; // RULE_01
				BUS.wr = 1'b1;
			end
			H_POP: begin
				BUS.addr[WSEL_LSB+1:WSEL_LSB] = WORD_D;
				BUS.rd = 1'b1;
			end
			default: ;
		endcase
	end

	// software read data, one cycle after the strobe
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rdata_r <= 32'h0;
		end else if (RD_I) begin
			case (ADDR_I)
				HREG_PTR: rdata_r <= ptr_r;
				HREG_CTRL: rdata_r <= ctrl_r;
				HREG_STAT: rdata_r <= {{(32-NQ-8){1'b0}}, BUS.pend, 7'h0, st_r != H_IDLE};
				HREG_RES: rdata_r <= res_r;
				HREG_DMA: rdata_r <= dma_r;
				default: rdata_r <= 32'h0;
			endcase
		end else begin
			rdata_r <= 32'h0;
		end
	end
	assign RDATA_O = rdata_r;

endmodule // hpqm_host
`default_nettype wire

// ### tb/hpqm_chk_sva.sv
// assertions on the queue bus and the queue-pend lines
`timescale 1ns/10ps
`default_nettype none
module hpqm_chk
	import hpqm_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// bus
	input wire logic [AW-1:0] addr,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic [NQ-1:0] pend,
	// queue-pend lines
	input wire logic [NQ-1:0] QPEND_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	// one-hot queue of a normal-region push or pop word access
	logic [NQ-1:0] q_oh;
	logic [NQ-1:0] pop_oh;
	logic [NQ-1:0] qp_mask;
	assign q_oh = (addr[QSEL_TOP:QSEL_LSB+QW] == '0 && addr[RGN_LSB+1:RGN_LSB] == RGN_MGMT
		&& addr[WSEL_LSB+1:WSEL_LSB] == WORD_D) ? NQ'(1) << addr[QSEL_LSB+QW-1:QSEL_LSB] : '0;
	assign pop_oh = rd ? q_oh : '0;
	assign qp_mask = (NQ'(1) << QP_LO) | (NQ'(1) << QP_HI);
	property p_strobe_excl;
		!(wr && rd);
	endproperty
	a_strobe_excl: assert property (p_strobe_excl) else $error("write and read together");
	property p_rd_idle;
		!rd |=> rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
	property p_proxy_rd;
		rd && addr[RGN_LSB+1:RGN_LSB] == RGN_PROXY |=> rdata == 32'h0;
	endproperty
	a_proxy_rd: assert property (p_proxy_rd) else $error("proxy read not zero");
	property p_push_pend;
		wr && q_oh != '0 |=> (pend & $past(q_oh)) == $past(q_oh);
	endproperty
	a_push_pend: assert property (p_push_pend) else $error("push left queue idle");
	property p_pop_empty;
		rd && q_oh != '0 && (pend & q_oh) == '0 |=> rdata == 32'h0 && (pend & $past(q_oh)) == '0;
	endproperty
	a_pop_empty: assert property (p_pop_empty) else $error("empty pop wrong");
	property p_pend_fall;
		($past(pend) & ~pend & ~$past(pop_oh)) == '0;
	endproperty
	a_pend_fall: assert property (p_pend_fall) else $error("pending fell without pop");
	property p_qpend_lines;
		(QPEND_O & ~qp_mask) == '0;
	endproperty
	a_qpend_lines: assert property (p_qpend_lines) else $error("queue-pend on plain queue");
	property p_qpend_pend;
		(QPEND_O & ~pend) == '0;
	endproperty
	a_qpend_pend: assert property (p_qpend_pend) else $error("queue-pend on empty queue");
endmodule // hpqm_chk
`default_nettype wire

// ### tb/hw_packet_queue_manager_tb.sv
// self-checking bench driving the host register port
`timescale 1ns/10ps
`default_nettype none
module hw_packet_queue_manager_tb;
	import hpqm_pkg::*;
	logic clk;
	logic rst_n;
	logic [4:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic [NQ-1:0] qpend;
	logic [31:0] got;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	int i;
	// the two ends and the checker
	hpqm_bus_if bus_if();
	hpqm_dev hpqm_dev_inst (.CLK_I(clk), .RST_N_I(rst_n), .BUS(bus_if), .QPEND_O(qpend));
	hpqm_host hpqm_host_inst (.CLK_I(clk), .RST_N_I(rst_n), .BUS(bus_if), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
	hpqm_chk hpqm_chk_inst (.CLK_I(clk), .RST_N_I(rst_n), .addr(bus_if.addr), .wr(bus_if.wr),
		.rd(bus_if.rd), .rdata(bus_if.rdata), .pend(bus_if.pend), .QPEND_O(qpend));
	// clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic stop_test();
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			$display("[ERR] %0t timeout", $time);
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// register port cycles
	task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// command, then poll busy
	task automatic run_cmd(input logic [2:0] op, input logic [2:0] q, input logic [1:0] c);
		logic [31:0] s;
		s = 32'h1;
		reg_wr(HREG_CMD, (32'(op) << CMD_OP_LSB) | (32'(q) << CMD_Q_LSB)
			| (32'(c) << CMD_CORE_LSB));
		for (int n = 0; n < 40 && s[0] !== 1'b0; n++)
			reg_rd(HREG_STAT, s);
		chk(32'(s[0]), 32'h0);
	endtask
	task automatic push(input logic [2:0] q, input logic [31:0] p);
		reg_wr(HREG_PTR, p);
		run_cmd(OP_PUSH, q, 2'h0);
	endtask
	task automatic pop(input logic [2:0] q, input logic [31:0] e);
		run_cmd(OP_POP, q, 2'h0);
		reg_rd(HREG_RES, got);
		chk(got, e);
	endtask
	task automatic set_ctrl(input logic [2:0] q, input logic [31:0] c);
		reg_wr(HREG_CTRL, c);
		run_cmd(OP_SETC, q, 2'h0);
	endtask
	task automatic pair(input logic [31:0] c, input logic [31:0] p, input logic [1:0] core);
		reg_wr(HREG_CTRL, c);
		reg_wr(HREG_PTR, p);
		run_cmd(OP_PAIR, 3'h0, core);
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		addr = 5'h0;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		reg_rd(HREG_STAT, got);
		chk(got, HREG_RST);
		reg_rd(5'h18, got);
		chk(got, 32'h0);
		chk(32'(qpend), 32'h0);
		// tail by default, head by control bit, empty pop
		for (i = 0; i < 3; i++)
			push(3'h1, 32'ha000_0010 + i);
		chk(32'(bus_if.pend), 32'h2);
		pop(3'h1, 32'ha000_0010);
		set_ctrl(3'h1, 32'h8000_0000);
		reg_rd(HREG_CTRL, got);
		chk(got, 32'h8000_0000);
		push(3'h1, 32'hb000_0003);
		pop(3'h1, 32'hb000_0003);
		set_ctrl(3'h1, CTRL_RST);
		push(3'h1, 32'hb000_0004);
		pop(3'h1, 32'ha000_0011);
		pop(3'h1, 32'ha000_0012);
		pop(3'h1, 32'hb000_0004);
		pop(3'h1, 32'h0);
		chk(32'(bus_if.pend), 32'h0);
		// every queue has its own address set
		for (i = 0; i < NQ; i++)
			push(3'(i), 32'hc000_0000 + i);
		chk(32'(bus_if.pend), 32'hff);
		reg_rd(HREG_STAT, got);
		chk(got, 32'h0000_ff00);
		chk(32'(qpend), 32'h0c);
		for (i = NQ - 1; i >= 0; i--)
			pop(3'(i), 32'hc000_0000 + i);
		// threshold of three
		reg_wr(HREG_PTR, 32'h3);
		reg_rd(HREG_PTR, got);
		chk(got, 32'h3);
		run_cmd(OP_THR, QP_LO, 2'h0);
		push(QP_LO, 32'hd000_0001);
		push(QP_LO, 32'hd000_0002);
		chk(32'(qpend), 32'h0);
		push(QP_LO, 32'hd000_0003);
		chk(32'(qpend), 32'h4);
		for (i = 1; i < 4; i++)
			pop(QP_LO, 32'hd000_0000 + i);
		chk(32'(qpend), 32'h0);
		// proxy pairs from each core, then a head pair
		for (i = 0; i < NC; i++)
			pair(CTRL_RST, 32'he000_0000 + i, 2'(i));
		push(3'h0, 32'he000_0010);
		pair(32'h8000_0000, 32'he000_0020, 2'h2);
		pop(3'h0, 32'he000_0020);
		for (i = 0; i < NC; i++)
			pop(3'h0, 32'he000_0000 + i);
		pop(3'h0, 32'he000_0010);
		set_ctrl(3'h0, CTRL_RST);
		// transmit channel: idle while off, recycles when on
		push(3'h0, 32'hf000_0001);
		repeat (8) @(posedge clk);
		chk(32'(bus_if.pend), 32'h1);
		reg_wr(HREG_DMA, 32'h0000_0701);
		reg_rd(HREG_DMA, got);
		chk(got, 32'h0000_0701);
		for (i = 0; i < 50 && bus_if.pend[7] !== 1'b1; i++)
			@(posedge clk);
		chk(32'(bus_if.pend), 32'h80);
		reg_wr(HREG_DMA, HREG_RST);
		pop(3'h7, 32'hf000_0001);
		// receive through each free queue
		for (i = 0; i < 4; i++) begin
			reg_wr(HREG_DMA, 32'((i << DMA_FREEQ_LSB) | (3 << DMA_RXQ_LSB)));
			push(FREEQ_BASE + 3'(i), 32'h9000_0000 + i);
			run_cmd(OP_RX, 3'h0, 2'h0);
			chk(32'(bus_if.pend), 32'h8);
			pop(3'h3, 32'h9000_0000 + i);
		end
		run_cmd(OP_RX, 3'h0, 2'h0);
		chk(32'(bus_if.pend), 32'h0);
		// mid-run reset empties queues and restores tail placement
		set_ctrl(3'h1, 32'h8000_0000);
		push(3'h1, 32'h5000_0001);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk(32'(bus_if.pend), 32'h0);
		reg_rd(HREG_PTR, got);
		chk(got, HREG_RST);
		push(3'h1, 32'h5000_0002);
		push(3'h1, 32'h5000_0003);
		pop(3'h1, 32'h5000_0002);
		pop(3'h1, 32'h5000_0003);
		pop(3'h1, 32'h0);
		stop_test();
	end
endmodule // hw_packet_queue_manager_tb
`default_nettype wire
